// ==== rtl/node_state_report.sv ====
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module node_state_report
    import node_state_pkg::*;
(
    // clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // device state from the protocol engine
    input  wire logic                    fn_enable,
    input  wire logic                    master_role,
    input  wire logic                    hb_alarm_en,
    input  wire logic [6:0]              own_addr,
    input  wire logic [15:0]             bit_rate_kbps,
    input  wire logic [15:0]             profile_ver,
    input  wire local_cond_t             local_cond,
    input  wire node_cond_t [NODES-1:0]  node_cond,
    // axi4-lite write address
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [11:0]             s_axi_awaddr,
    // axi4-lite write data
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    // axi4-lite write response
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output logic [1:0]                   s_axi_bresp,
    // axi4-lite read address
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    input  wire logic [11:0]             s_axi_araddr,
    // axi4-lite read data
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    // interrupt
    output logic                         irq
);

    logic [15:0]       state_r;              // local state word
    logic [15:0]       code_r [NODES];       // per-node error codes
    logic [NODES-1:0]  flag_r;               // fault flags, node k+1 at bit k
    logic [15:0]       rate_r;               // bit-rate word
    logic [15:0]       ver_r;                // profile version word
    logic [2:0]        stat_r;               // sticky: flags, state, codes changed
    logic [2:0]        mask_r;               // interrupt mask
    logic [15:0]       state_nxt;
    logic [NODES-1:0]  flag_nxt;
    logic              code_chg;
    logic              aw_got_r;
    logic              w_got_r;
    logic [11:0]       awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;

    // per-node code: lowest cause wins, zero when unconfigured or disabled
    function automatic logic [15:0] node_code(input node_cond_t c);
        logic [15:0] v;
        v = CODE_OK;
        if (c.configured) begin
            for (int i = CAUSES - 1; i >= 0; i--) begin
                if (c.cause[i]) begin
                    v = CODE_E0 | 16'(i);                                  // RULE5 RULE6 RULE7 RULE8
                end
            end
        end
        return v;
    endfunction : node_code

    // local state encoder; hardware faults outrank configuration states
    always_comb begin
        state_nxt = CODE_OK;
        if (!fn_enable) begin
            state_nxt = CODE_OK;                                            // RULE17
        end else if (local_cond.mem_fault && master_role) begin
            state_nxt = CODE_F8;                                            // RULE11
        end else if (local_cond.bus_off) begin
            state_nxt = CODE_F4;                                            // RULE10 RULE14
        end else if (local_cond.tx_full) begin
            state_nxt = CODE_FB;                                            // RULE11 RULE14
        end else if (local_cond.rx_full) begin
            state_nxt = CODE_FC;                                            // RULE11 RULE14
        end else if (master_role) begin
            if (own_addr < ADDR_MIN || own_addr > ADDR_MAX) begin
                state_nxt = CODE_F5;                                        // RULE10
            end else if (local_cond.cfg_loading) begin
                state_nxt = CODE_F2;                                        // RULE9
            end else if (local_cond.cfg_error) begin
                state_nxt = CODE_F3;                                        // RULE9
            end else if (local_cond.no_slaves) begin
                state_nxt = CODE_F1;                                        // RULE9
            end
        end else begin
            if (local_cond.initializing) begin
                state_nxt = CODE_A0;                                        // RULE12
            end else if (local_cond.cfg_loading) begin
                state_nxt = CODE_A3;                                        // RULE12
            end else if (local_cond.hb_timeout && hb_alarm_en) begin
                // without the alarm a lost link latches nothing
                state_nxt = CODE_B0;                                        // RULE13 RULE15
            end else if (local_cond.pdo_len_bad) begin
                state_nxt = CODE_B1;                                        // RULE13
            end else if (local_cond.preop) begin
                state_nxt = CODE_A1;                                        // RULE12
            end
        end
    end

    // fault flag: any cause on a configured node, master role only
    always_comb begin
        for (int k = 0; k < NODES; k++) begin
            flag_nxt[k] = fn_enable && master_role && node_cond[k].configured
                          && (|node_cond[k].cause);                         // RULE2 RULE3
        end
    end

    // status words follow the live state every cycle, no acknowledge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= CODE_OK;
            flag_r  <= '0;
            rate_r  <= 16'h0000;
            ver_r   <= 16'h0000;
        end else begin
            state_r <= state_nxt;                                           // RULE18
            flag_r  <= flag_nxt;                                            // RULE18
            rate_r  <= fn_enable ? bit_rate_kbps : 16'h0000;                // RULE16 RULE17
            ver_r   <= fn_enable ? profile_ver : 16'h0000;                  // RULE16 RULE17
        end
    end

    // one code word per node, node 1 at word 0
    generate
        for (genvar g = 0; g < NODES; g++) begin : g_node
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    code_r[g] <= CODE_OK;
                end else if (fn_enable && master_role) begin
                    code_r[g] <= node_code(node_cond[g]);                   // RULE1 RULE4
                end else begin
                    code_r[g] <= CODE_OK;                                   // RULE17
                end
            end
        end
    endgenerate

    // a code change while enabled in master role raises one event
    always_comb begin
        code_chg = 1'b0;
        for (int k = 0; k < NODES; k++) begin
            if (fn_enable && master_role && node_code(node_cond[k]) != code_r[k]) begin
                code_chg = 1'b1;
            end
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 12'h000;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                // only the mask takes writes; status words refuse them
                s_axi_bresp  <= (awaddr_r[11:2] == OFS_IRQ_MASK[11:2]) ? RESP_OKAY : RESP_SLVERR;  // RULE18
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // mask register, low byte lane
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= 3'h0;
        end else if (aw_got_r && w_got_r && !s_axi_bvalid
                     && awaddr_r[11:2] == OFS_IRQ_MASK[11:2] && wstrb_r[0]) begin
            mask_r <= wdata_r[2:0];
        end
    end

    // read channel, one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr >= OFS_CODES && s_axi_araddr <= OFS_CODES_END) begin
                s_axi_rdata <= {16'h0000, code_r[s_axi_araddr[7:2]]};      // RULE4
            end else begin
                unique case (s_axi_araddr[11:2])
                    OFS_STATE[11:2]:    s_axi_rdata <= {16'h0000, state_r};
                    OFS_FLAGS0[11:2]:   s_axi_rdata <= {16'h0000, flag_r[15:0]};   // RULE2
                    10'h002:            s_axi_rdata <= {16'h0000, flag_r[31:16]};
                    10'h003:            s_axi_rdata <= {16'h0000, flag_r[47:32]};
                    10'h004:            s_axi_rdata <= {16'h0000, flag_r[63:48]};
                    OFS_VERSION[11:2]:  s_axi_rdata <= {16'h0000, ver_r};
                    OFS_RATE[11:2]:     s_axi_rdata <= {16'h0000, rate_r};
                    OFS_IRQ_STAT[11:2]: s_axi_rdata <= {29'h0, stat_r};
                    OFS_IRQ_MASK[11:2]: s_axi_rdata <= {29'h0, mask_r};
                    default:            s_axi_rresp <= RESP_SLVERR;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // sticky events; a new event beats the clear-on-read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= 3'h0;
            irq    <= 1'b0;
        end else begin
            logic [2:0] ev;
            logic [2:0] nx;
            ev = {code_chg, state_nxt != state_r, flag_nxt != flag_r};
            nx = stat_r;
            if (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == OFS_IRQ_STAT[11:2]) begin
                nx = 3'h0;
            end
            nx     = nx | ev;
            stat_r <= nx;
            irq    <= |(nx & mask_r);
        end
    end

    // the node 1 fault bit and a nonzero node 1 code agree in every cycle
    property p_flag_code;
        @(posedge aclk) disable iff (!aresetn)
        (flag_r[0] == (code_r[0] != CODE_OK));
    endproperty
    a_flag_code: assert property (p_flag_code) else $error("flag and code disagree");  // RULE3

    property p_e0;
        @(posedge aclk) disable iff (!aresetn)
        (fn_enable && master_role && node_cond[0].configured && node_cond[0].cause[0]) |=> code_r[0] == CODE_E0;
    endproperty
    a_e0: assert property (p_e0) else $error("emergency not reported as e0");  // RULE5

    property p_unconf;
        @(posedge aclk) disable iff (!aresetn)
        !node_cond[5].configured |=> code_r[5] == CODE_OK;
    endproperty
    a_unconf: assert property (p_unconf) else $error("unconfigured node code nonzero");  // RULE5

    property p_disabled;
        @(posedge aclk) disable iff (!aresetn)
        !fn_enable |=> state_r == CODE_OK && flag_r == '0 && rate_r == 16'h0000;
    endproperty
    a_disabled: assert property (p_disabled) else $error("words live while disabled");  // RULE17

    property p_busoff;
        @(posedge aclk) disable iff (!aresetn)
        (fn_enable && local_cond.bus_off && !(master_role && local_cond.mem_fault)) |=> state_r == CODE_F4;
    endproperty
    a_busoff: assert property (p_busoff) else $error("bus-off not f4");  // RULE10

    property p_hb_off;
        @(posedge aclk) disable iff (!aresetn)
        (!hb_alarm_en && !master_role) |=> state_r != CODE_B0;
    endproperty
    a_hb_off: assert property (p_hb_off) else $error("b0 with alarm disabled");  // RULE15

    property p_rate;
        @(posedge aclk) disable iff (!aresetn)
        fn_enable |=> rate_r == $past(bit_rate_kbps);
    endproperty
    a_rate: assert property (p_rate) else $error("bit rate word stale");  // RULE16

    property p_bad_addr;
        @(posedge aclk) disable iff (!aresetn)
        (fn_enable && master_role && own_addr == 7'h00 && !local_cond.bus_off && !local_cond.tx_full
         && !local_cond.rx_full && !local_cond.mem_fault) |=> state_r == CODE_F5;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad address not f5");  // RULE10

    property p_ro;
        @(posedge aclk) disable iff (!aresetn)
        (aw_got_r && w_got_r && !s_axi_bvalid && awaddr_r == OFS_STATE) |=> s_axi_bresp == RESP_SLVERR;
    endproperty
    a_ro: assert property (p_ro) else $error("status write accepted");  // RULE18

endmodule : node_state_report

// ==== rtl/node_state_pkg.sv ====
// Contract
// (RULE1) master tracks at most sixty-four slave nodes
// (RULE2) four fault words, bit0 lowest node
// (RULE3) fault bit clear healthy, set abnormal
// (RULE4) sixty-four error words, word k node k+1
// (RULE5) code 0 no error, e0 emergency
// (RULE6) e1 pdo length mismatch, e2 pdo missing
// (RULE7) e3 sdo fail, e4 pdo cfg, e5 key
// (RULE8) e6 absent, e7 timeout, e8 duplicate id
// (RULE9) master state 0, f1, f2, f3
// (RULE10) master f4 bus-off, f5 setting error
// (RULE11) master f8 memory, fb tx full, fc rx full
// (RULE12) slave 0, a0 init, a1 preop, a3 download
// (RULE13) slave b0 heartbeat timeout, b1 pdo length
// (RULE14) slave also f4, fb, fc
// (RULE15) heartbeat alarm off: reconnect reads zero
// (RULE16) bit rate in kbit/s, profile version word
// (RULE17) words maintained only while function enabled
// (RULE18) words read-only, follow state live
package node_state_pkg;
    localparam int          NODES         = 64;
    localparam int          CAUSES        = 9;
    localparam logic [11:0] OFS_STATE     = 12'h000;
    localparam logic [11:0] OFS_FLAGS0    = 12'h004;
    localparam logic [11:0] OFS_VERSION   = 12'h014;
    localparam logic [11:0] OFS_RATE      = 12'h018;
    localparam logic [11:0] OFS_IRQ_STAT  = 12'h01c;
    localparam logic [11:0] OFS_IRQ_MASK  = 12'h020;
    localparam logic [11:0] OFS_CODES     = 12'h100;
    localparam logic [11:0] OFS_CODES_END = 12'h1fc;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [15:0] CODE_OK = 16'h0000;
    localparam logic [15:0] CODE_E0 = 16'h00e0;
    localparam logic [15:0] CODE_E1 = 16'h00e1;
    localparam logic [15:0] CODE_E2 = 16'h00e2;
    localparam logic [15:0] CODE_E3 = 16'h00e3;
    localparam logic [15:0] CODE_E4 = 16'h00e4;
    localparam logic [15:0] CODE_E5 = 16'h00e5;
    localparam logic [15:0] CODE_E6 = 16'h00e6;
    localparam logic [15:0] CODE_E7 = 16'h00e7;
    localparam logic [15:0] CODE_E8 = 16'h00e8;
    localparam logic [15:0] CODE_F1 = 16'h00f1;
    localparam logic [15:0] CODE_F2 = 16'h00f2;
    localparam logic [15:0] CODE_F3 = 16'h00f3;
    localparam logic [15:0] CODE_F4 = 16'h00f4;
    localparam logic [15:0] CODE_F5 = 16'h00f5;
    localparam logic [15:0] CODE_F8 = 16'h00f8;
    localparam logic [15:0] CODE_FB = 16'h00fb;
    localparam logic [15:0] CODE_FC = 16'h00fc;
    localparam logic [15:0] CODE_A0 = 16'h00a0;
    localparam logic [15:0] CODE_A1 = 16'h00a1;
    localparam logic [15:0] CODE_A3 = 16'h00a3;
    localparam logic [15:0] CODE_B0 = 16'h00b0;
    localparam logic [15:0] CODE_B1 = 16'h00b1;
    localparam logic [6:0]  ADDR_MIN = 7'h01;
    localparam logic [6:0]  ADDR_MAX = 7'h7f;
    // per-node cause bits, index = code low nibble (e0..e8)
    typedef struct packed {
        logic configured;
        logic [CAUSES-1:0] cause;
    } node_cond_t;
    // local conditions for the device itself
    typedef struct packed {
        logic no_slaves;
        logic cfg_loading;
        logic cfg_error;
        logic bus_off;
        logic mem_fault;
        logic tx_full;
        logic rx_full;
        logic initializing;
        logic preop;
        logic hb_timeout;
        logic pdo_len_bad;
    } local_cond_t;
endpackage : node_state_pkg

// ==== tb/canopen_peer_model.sv ====
`timescale 1ns/1ns
module canopen_peer_model
    import node_state_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // event request from the bench
    input  wire logic                  ev_we,
    input  wire logic [5:0]            ev_node,
    input  wire node_cond_t            ev_cond,
    // per-node view as seen by the reporting block
    output node_cond_t [NODES-1:0]     node_cond
);
    // one node changes per event, the others keep their view
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            node_cond <= '0;
        end else if (ev_we) begin
            node_cond[ev_node] <= ev_cond;
        end
    end
endmodule : canopen_peer_model

// ==== tb/tb_canopen_node_state_reporting.sv ====
`timescale 1ns/1ns
module tb_canopen_node_state_reporting
    import node_state_pkg::*;
;
    // design side
    logic                   aclk, aresetn, fn_enable, master_role, hb_alarm_en, irq;
    logic [6:0]             own_addr;
    logic [15:0]            bit_rate_kbps, profile_ver;
    local_cond_t            local_cond;
    node_cond_t [NODES-1:0] node_cond;
    // peer event request
    logic                   ev_we;
    logic [5:0]             ev_node;
    node_cond_t             ev_cond;
    // register bus
    logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                   s_axi_rvalid, s_axi_rready;
    logic [11:0]            s_axi_awaddr, s_axi_araddr;
    logic [31:0]            s_axi_wdata, s_axi_rdata;
    logic [3:0]             s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp;
    int                     failures = 0;
    int                     n_compared = 0;
    int                     cyc = 0;

    node_state_report DUT (.aclk, .aresetn, .fn_enable, .master_role, .hb_alarm_en, .own_addr,
        .bit_rate_kbps, .profile_ver, .local_cond, .node_cond, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
    canopen_peer_model peer (.aclk, .aresetn, .ev_we, .ev_node, .ev_cond, .node_cond);

    // clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // hang guard: the whole run needs far fewer cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t data %h expected %h", $time, got, exp);
        end
    endtask : check_data

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t resp %h expected %h", $time, got, exp);
        end
    endtask : check_resp

    // read: hold arvalid until taken, rready until rvalid; a spare edge keeps drives apart
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        // no cycle count assumed; only the hang guard ends a wait
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check_data(d, exp);
        check_resp(r, er);
    endtask : rd_chk

    // status words lag one cycle; three edges leave margin
    task automatic set_local(input local_cond_t c);
        local_cond <= c;
        repeat (3) @(posedge aclk);
    endtask : set_local

    task automatic set_node(input int k, input logic [CAUSES-1:0] c, input logic cfg);
        ev_node <= 6'(k - 1);
        ev_cond <= '{configured: cfg, cause: c};
        ev_we   <= 1'b1;
        @(posedge aclk);
        ev_we   <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : set_node

    function automatic logic [11:0] flag_a(input int k);
        return OFS_FLAGS0 + 12'(4 * ((k - 1) / 16));
    endfunction : flag_a

    function automatic logic [11:0] code_a(input int k);
        return OFS_CODES + 12'(4 * (k - 1));
    endfunction : code_a

    // function off: state, flag, code and rate words read zero despite live conditions
    task automatic t_disabled();
        set_node(1, 9'h040, 1'b1);
        set_local(11'h020);
        rd_chk(OFS_STATE, 32'h0);
        rd_chk(OFS_FLAGS0, 32'h0);
        rd_chk(code_a(1), 32'h0);
        rd_chk(OFS_RATE, 32'h0);
        set_node(1, 9'h000, 1'b0);
        set_local(11'h000);
    endtask : t_disabled

    // identity words, read-only refusal, unmapped place
    task automatic t_words();
        logic [1:0] r;
        fn_enable <= 1'b1;
        set_local(11'h020);
        rd_chk(OFS_VERSION, {16'h0, profile_ver});
        rd_chk(OFS_RATE, {16'h0, bit_rate_kbps});
        axi_wr(OFS_STATE, 32'h0000_00aa, r);
        check_resp(r, RESP_SLVERR);
        rd_chk(OFS_STATE, {16'h0, CODE_FB});
        rd_chk(12'h024, 32'h0, RESP_SLVERR);
        set_local(11'h000);
        rd_chk(OFS_STATE, 32'h0);
    endtask : t_words

    // one condition at a time, walking from the top bit of the struct down
    task automatic t_local(input logic master, input logic [15:0] tbl [11]);
        master_role <= master;
        hb_alarm_en <= 1'b1;
        for (int j = 0; j < 11; j++) begin
            if (tbl[j] != 16'hffff) begin
                set_local(local_cond_t'(11'h400 >> j));
                rd_chk(OFS_STATE, {16'h0, tbl[j]});
            end
        end
        set_local(11'h000);
    endtask : t_local

    task automatic t_master_extra();
        master_role <= 1'b1;
        set_local(11'h0a0);
        rd_chk(OFS_STATE, {16'h0, CODE_F4});
        set_local(11'h000);
        own_addr <= 7'h00;
        set_local(11'h000);
        rd_chk(OFS_STATE, {16'h0, CODE_F5});
        own_addr <= 7'h05;
        set_local(11'h000);
    endtask : t_master_extra

    // heartbeat loss with alarm off must not show or latch
    task automatic t_heartbeat();
        master_role <= 1'b0;
        hb_alarm_en <= 1'b0;
        set_local(11'h002);
        rd_chk(OFS_STATE, 32'h0);
        set_local(11'h000);
        rd_chk(OFS_STATE, 32'h0);
        hb_alarm_en <= 1'b1;
        set_local(11'h002);
        rd_chk(OFS_STATE, {16'h0, CODE_B0});
        set_local(11'h000);
        rd_chk(OFS_STATE, 32'h0);
    endtask : t_heartbeat

    task automatic t_nodes();
        int ks[5] = '{1, 16, 17, 33, 64};
        int k;
        master_role <= 1'b1;
        foreach (ks[n]) begin
            k = ks[n];
            set_node(k, '0, 1'b1);
            rd_chk(flag_a(k), 32'h0);
            rd_chk(code_a(k), 32'h0);
            for (int i = 0; i < CAUSES; i++) begin
                set_node(k, 9'h1 << i, 1'b1);
                rd_chk(code_a(k), {16'h0, CODE_E0 + 16'(i)});
                rd_chk(flag_a(k), 32'h1 << ((k - 1) % 16));
            end
            set_node(k, '0, 1'b0);
            rd_chk(code_a(k), 32'h0);
        end
        set_node(5, 9'h048, 1'b1);
        rd_chk(code_a(5), {16'h0, CODE_E3});
        set_node(5, '0, 1'b0);
    endtask : t_nodes

    // a set mask bit lets its event through; a cleared one holds irq off; read clears status
    task automatic t_irq();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(OFS_IRQ_MASK, 32'h0, r);
        axi_rd(OFS_IRQ_STAT, d, r);
        set_local(11'h020);
        check_data({31'h0, irq}, 32'h0);
        rd_chk(OFS_IRQ_STAT, 32'h2);
        axi_wr(OFS_IRQ_MASK, 32'h2, r);
        check_resp(r, RESP_OKAY);
        set_local(11'h000);
        check_data({31'h0, irq}, 32'h1);
        rd_chk(OFS_IRQ_MASK, 32'h2);
        rd_chk(OFS_IRQ_STAT, 32'h2);
        repeat (2) @(posedge aclk);
        check_data({31'h0, irq}, 32'h0);
    endtask : t_irq

    initial begin
        logic [15:0] m_tbl [11];
        logic [15:0] s_tbl [11];
        m_tbl = '{CODE_F1, CODE_F2, CODE_F3, CODE_F4, CODE_F8, CODE_FB, CODE_FC,
                  16'hffff, 16'hffff, 16'hffff, 16'hffff};
        s_tbl = '{16'hffff, CODE_A3, 16'hffff, CODE_F4, 16'hffff, CODE_FB, CODE_FC,
                  CODE_A0, CODE_A1, CODE_B0, CODE_B1};
        aresetn = 1'b0;
        fn_enable = 1'b0;
        master_role = 1'b1;
        hb_alarm_en = 1'b0;
        own_addr = 7'h05;
        bit_rate_kbps = 16'h03e8;
        profile_ver = 16'h0402;
        local_cond = '0;
        ev_we = 1'b0;
        ev_node = '0;
        ev_cond = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_disabled();
        t_words();
        t_local(1'b1, m_tbl);
        t_master_extra();
        t_local(1'b0, s_tbl);
        t_heartbeat();
        t_nodes();
        t_irq();
        print_verdict();
    end
endmodule : tb_canopen_node_state_reporting
